/* File: inc/smfm_pkg.sv */
// Package for the safe motion fault monitor: fault codes, stop responses, carriers.
// Assumes speed and position feedback arrive as signed words, one sample per valid pulse.
package smfm_pkg;
   localparam int SMFM_FB_W = 24;
   localparam int SMFM_NFAULT = 7;
   // Fault bit positions inside the latched fault vector.
   localparam int SMFM_F_LS3 = 0;
   localparam int SMFM_F_LS4 = 1;
   localparam int SMFM_F_POS = 2;
   localparam int SMFM_F_NEG = 3;
   localparam int SMFM_F_SS1 = 4;
   localparam int SMFM_F_SS2 = 5;
   localparam int SMFM_F_SOS = 6;
   // Fault codes as group and sub-code, packed as {group[11:0], sub[3:0]}.
   localparam logic [15:0] SMFM_CODE_NONE = 16'h0000;
   localparam logic [15:0] SMFM_CODE_LS3 = 16'ha02;
   localparam logic [15:0] SMFM_CODE_LS4 = 16'ha03;
   localparam logic [15:0] SMFM_CODE_POS = 16'ha50;
   localparam logic [15:0] SMFM_CODE_NEG = 16'ha51;
   localparam logic [15:0] SMFM_CODE_SS1 = 16'haa0;
   localparam logic [15:0] SMFM_CODE_SS2 = 16'haa1;
   localparam logic [15:0] SMFM_CODE_SOS = 16'haa2;
   localparam logic [SMFM_NFAULT-1:0] SMFM_FAULT_RST = '0;

   // Stop response that a monitoring function asks for on fault.
   typedef enum logic [1:0] {
      SMFM_STOP_NONE = 2'b00,
      SMFM_STOP_TORQUE_OFF = 2'b01,
      SMFM_STOP_FIRST = 2'b10,
      SMFM_STOP_SECOND = 2'b11
   } smfm_stop_t;

   // One feedback sample.
   typedef struct packed {
      logic signed [SMFM_FB_W-1:0] speed;
      logic signed [SMFM_FB_W-1:0] pos_delta;
   } smfm_fb_t;

   // Configured limits; all are magnitudes, non-negative.
   typedef struct packed {
      logic [SMFM_FB_W-1:0] ls3_limit;
      logic [SMFM_FB_W-1:0] ls4_limit;
      logic [SMFM_FB_W-1:0] dir_zero_speed;
      logic [SMFM_FB_W-1:0] dir_zero_pos;
      logic [SMFM_FB_W-1:0] ramp_ceiling;
      logic [SMFM_FB_W-1:0] sos_speed;
      logic [SMFM_FB_W-1:0] sos_pos;
   } smfm_limits_t;

   // Active monitoring functions.
   typedef struct packed {
      logic ls3;
      logic ls4;
      logic pos_lock;
      logic neg_lock;
      logic ss1_ramp;
      logic ss2_ramp;
      logic safe_operating_stop;
   } smfm_mon_t;
endpackage

/* File: design/smfm_record.sv */
// Fault record store: keeps the feedback sample present when a fault is detected.
// Assumes the writer pulses wr_en for exactly one cycle per recorded fault.
`timescale 1ns/1ps
module smfm_record #(
   parameter int DEPTH = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire smfm_pkg::smfm_fb_t wr_data,
   input wire logic [15:0] wr_code,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output smfm_pkg::smfm_fb_t rd_data,
   output logic [15:0] rd_code,
   output logic [$clog2(DEPTH):0] count
);
   import smfm_pkg::*;
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("smfm_record DEPTH must be a power of two >= 2");
   end

   smfm_fb_t mem_fb [DEPTH];
   logic [15:0] mem_code [DEPTH];
   logic [AW-1:0] wptr_reg, wptr_next;
   logic [AW:0] cnt_reg, cnt_next;

   // Entries wrap, so the oldest record is overwritten when full.
   always_comb begin
      wptr_next = wptr_reg;
      cnt_next = cnt_reg;
      if (wr_en) begin
         wptr_next = wptr_reg + 1'b1;
         if (cnt_reg != DEPTH[AW:0]) cnt_next = cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wptr_reg <= wptr_next;
         cnt_reg <= cnt_next;
      end
   end

   // Memory has no reset; read data are registered.
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem_fb[wptr_reg] <= wr_data;
         mem_code[wptr_reg] <= wr_code;
      end
      rd_data <= mem_fb[rd_idx];
      rd_code <= mem_code[rd_idx];
   end

   assign count = cnt_reg;
endmodule

/* File: design/smfm_top.sv */
// Safe motion fault monitor: compares feedback with configured limits and latches fault codes.
// Assumes feedback, limits and monitor enables are synchronous to mclk and stable per sample.
`timescale 1ns/1ps
// Notes on behaviour
// - With stage-three speed monitoring active, speed magnitude above its limit raises the stage-three fault.
// - With stage-four speed monitoring active, speed magnitude above its limit raises code E160.3.
// - With positive motion locked, moving positively beyond the allowance raises code E165.0.
// - Positive violation is positive speed above the zero-speed window or positive travel above the zero-position window.
// - With negative motion locked, moving negatively beyond the allowance raises code E165.1.
// - Negative violation is negative speed above the zero-speed window or negative travel above the zero-position window.
// - Once the first stop mode ramp monitor runs, a ramp outside the ceiling raises code E170.0.
// - Once the second stop mode ramp monitor runs, a ramp outside the ceiling raises code E170.1.
// - In safe operating stop, speed or position change above the threshold raises code E170.2.
// - A fault that seizes the latch with a torque-off response stores the speed and position seen at detection.
module smfm_top #(
   parameter int REC_DEPTH = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic fb_valid,
   input wire smfm_pkg::smfm_fb_t fb,
   input wire smfm_pkg::smfm_limits_t limits,
   input wire smfm_pkg::smfm_mon_t mon,
   input wire smfm_pkg::smfm_stop_t stop_cfg_ls,
   input wire smfm_pkg::smfm_stop_t stop_cfg_dir,
   input wire smfm_pkg::smfm_stop_t stop_cfg_ramp,
   input wire logic fault_clear,
   input wire logic [$clog2(REC_DEPTH)-1:0] rec_idx,
   output logic [smfm_pkg::SMFM_NFAULT-1:0] fault_flags,
   output logic [15:0] fault_code,
   output logic fault_active,
   output smfm_pkg::smfm_stop_t stop_request,
   output smfm_pkg::smfm_fb_t rec_data,
   output logic [15:0] rec_code,
   output logic [$clog2(REC_DEPTH):0] rec_count
);
   import smfm_pkg::*;
   localparam int W = SMFM_FB_W;

   initial begin
      if (REC_DEPTH < 2) $error("smfm_top REC_DEPTH must be at least 2");
   end

   // Magnitudes and sign-split components of the sample.
   logic [W-1:0] spd_abs, pos_abs, spd_pos, spd_neg, pd_pos, pd_neg;
   logic [W-1:0] ramp_abs;
   logic signed [W-1:0] prev_speed_reg, prev_speed_next;
   logic signed [W:0] ramp_diff;
   logic ramp_armed_reg, ramp_armed_next;
   logic [SMFM_NFAULT-1:0] hit;

   always_comb begin
      spd_abs = fb.speed[W-1] ? W'(-fb.speed) : W'(fb.speed);
      pos_abs = fb.pos_delta[W-1] ? W'(-fb.pos_delta) : W'(fb.pos_delta);
      spd_pos = fb.speed[W-1] ? '0 : W'(fb.speed);
      spd_neg = fb.speed[W-1] ? W'(-fb.speed) : '0;
      pd_pos = fb.pos_delta[W-1] ? '0 : W'(fb.pos_delta);
      pd_neg = fb.pos_delta[W-1] ? W'(-fb.pos_delta) : '0;
      ramp_diff = (W+1)'(prev_speed_reg) - (W+1)'(fb.speed);
      ramp_abs = ramp_diff[W] ? W'(-ramp_diff) : W'(ramp_diff);
   end

   // Per-sample comparisons; each fires only while its monitor is active.
   always_comb begin
      hit = '0;
      if (fb_valid) begin
         hit[SMFM_F_LS3] = mon.ls3 && (spd_abs > limits.ls3_limit);
         hit[SMFM_F_LS4] = mon.ls4 && (spd_abs > limits.ls4_limit);
         hit[SMFM_F_POS] = mon.pos_lock && ((spd_pos > limits.dir_zero_speed) ||
            (pd_pos > limits.dir_zero_pos));
         hit[SMFM_F_NEG] = mon.neg_lock && ((spd_neg > limits.dir_zero_speed) ||
            (pd_neg > limits.dir_zero_pos));
         // Ramp needs one earlier sample, so the first sample after start only arms it.
         hit[SMFM_F_SS1] = mon.ss1_ramp && ramp_armed_reg && (ramp_abs > limits.ramp_ceiling);
         hit[SMFM_F_SS2] = mon.ss2_ramp && ramp_armed_reg && (ramp_abs > limits.ramp_ceiling);
         hit[SMFM_F_SOS] = mon.safe_operating_stop && ((spd_abs > limits.sos_speed) || (pos_abs > limits.sos_pos));
      end
   end

   // Ramp history tracking.
   always_comb begin
      prev_speed_next = prev_speed_reg;
      ramp_armed_next = ramp_armed_reg;
      if (!(mon.ss1_ramp || mon.ss2_ramp)) begin
         ramp_armed_next = 1'b0;
      end else if (fb_valid) begin
         prev_speed_next = fb.speed;
         ramp_armed_next = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prev_speed_reg <= '0;
         ramp_armed_reg <= 1'b0;
      end else begin
         prev_speed_reg <= prev_speed_next;
         ramp_armed_reg <= ramp_armed_next;
      end
   end

   // Priority encoder picks the code and response of the lowest new fault bit.
   logic [15:0] new_code;
   smfm_stop_t new_stop;
   always_comb begin
      new_code = SMFM_CODE_NONE;
      new_stop = SMFM_STOP_NONE;
      if (hit[SMFM_F_LS3]) begin
         new_code = SMFM_CODE_LS3;
         new_stop = stop_cfg_ls;
      end else if (hit[SMFM_F_LS4]) begin
         new_code = SMFM_CODE_LS4;
         new_stop = stop_cfg_ls;
      end else if (hit[SMFM_F_POS]) begin
         new_code = SMFM_CODE_POS;
         new_stop = stop_cfg_dir;
      end else if (hit[SMFM_F_NEG]) begin
         new_code = SMFM_CODE_NEG;
         new_stop = stop_cfg_dir;
      end else if (hit[SMFM_F_SS1]) begin
         new_code = SMFM_CODE_SS1;
         new_stop = stop_cfg_ramp;
      end else if (hit[SMFM_F_SS2]) begin
         new_code = SMFM_CODE_SS2;
         new_stop = stop_cfg_ramp;
      end else if (hit[SMFM_F_SOS]) begin
         new_code = SMFM_CODE_SOS;
         // A stop that is already standing still can only fall back to torque-off.
         new_stop = SMFM_STOP_TORQUE_OFF;
      end
   end

   // Fault latch: the first fault owns the code; set wins over a same-cycle clear.
   logic [SMFM_NFAULT-1:0] flags_reg, flags_next;
   logic [15:0] code_reg, code_next;
   smfm_stop_t stop_reg, stop_next;
   logic active_reg, active_next;
   logic rec_wr;
   always_comb begin
      flags_next = flags_reg;
      code_next = code_reg;
      stop_next = stop_reg;
      if (fault_clear) begin
         flags_next = SMFM_FAULT_RST;
         code_next = SMFM_CODE_NONE;
         stop_next = SMFM_STOP_NONE;
      end
      flags_next = flags_next | hit;
      if (|hit && (code_next == SMFM_CODE_NONE)) begin
         code_next = new_code;
         stop_next = new_stop;
      end
      active_next = |flags_next;
      // Record only the fault that owns the latch, when its response is torque-off.
      // The latch is seized when it is empty, or is being cleared in this same cycle.
      rec_wr = |hit && (fault_clear || (code_reg == SMFM_CODE_NONE)) &&
         (new_stop == SMFM_STOP_TORQUE_OFF);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flags_reg <= SMFM_FAULT_RST;
         code_reg <= SMFM_CODE_NONE;
         stop_reg <= SMFM_STOP_NONE;
         active_reg <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         code_reg <= code_next;
         stop_reg <= stop_next;
         active_reg <= active_next;
      end
   end

   smfm_record #(
      .DEPTH(REC_DEPTH)
   ) u_record (
      .mclk(mclk),
      .rst_n(rst_n),
      .wr_en(rec_wr),
      .wr_data(fb),
      .wr_code(new_code),
      .rd_idx(rec_idx),
      .rd_data(rec_data),
      .rd_code(rec_code),
      .count(rec_count)
   );

   assign fault_flags = flags_reg;
   assign fault_code = code_reg;
   assign fault_active = active_reg;
   assign stop_request = stop_reg;

   // Checks on fault detection and latching.
   a_ls3_fault: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_valid && mon.ls3 && (spd_abs > limits.ls3_limit) |=> fault_flags[SMFM_F_LS3])
      else $error("stage three overspeed not flagged");
   a_ls4_code: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_valid && mon.ls4 && (spd_abs > limits.ls4_limit) && !mon.ls3 && fault_code == SMFM_CODE_NONE
      |=> fault_code == SMFM_CODE_LS4)
      else $error("stage four code not latched");
   a_pos_lock: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_valid && mon.pos_lock && (pd_pos > limits.dir_zero_pos) |=> fault_flags[SMFM_F_POS])
      else $error("positive lock violation missed");
   a_pos_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      hit[SMFM_F_POS] |-> mon.pos_lock && (($signed(fb.speed) > $signed({1'b0, limits.dir_zero_speed})) ||
      ($signed(fb.pos_delta) > $signed({1'b0, limits.dir_zero_pos}))))
      else $error("positive fault without cause");
   a_neg_lock: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_valid && mon.neg_lock && (spd_neg > limits.dir_zero_speed) |=> fault_flags[SMFM_F_NEG])
      else $error("negative lock violation missed");
   a_neg_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      hit[SMFM_F_NEG] |-> mon.neg_lock && (($signed(fb.speed) < -$signed({1'b0, limits.dir_zero_speed})) ||
      ($signed(fb.pos_delta) < -$signed({1'b0, limits.dir_zero_pos}))))
      else $error("negative fault without cause");
   a_ss1_ramp: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_valid && mon.ss1_ramp && ramp_armed_reg && (ramp_abs > limits.ramp_ceiling) |=> fault_flags[SMFM_F_SS1])
      else $error("first stop ramp fault wrong");
   a_ss2_ramp: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_valid && mon.ss2_ramp && ramp_armed_reg && (ramp_abs > limits.ramp_ceiling) |=> fault_flags[SMFM_F_SS2])
      else $error("second stop ramp fault missed");
   a_sos_drift: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_valid && mon.safe_operating_stop && (pos_abs > limits.sos_pos) |=> fault_flags[SMFM_F_SOS] && fault_active)
      else $error("safe stop drift missed");
   a_rec_count: assert property (@(posedge mclk) disable iff (!rst_n)
      rec_wr && rec_count == 0 |=> rec_count == 1)
      else $error("fault record not stored");
   a_latch_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      fault_active && !fault_clear |=> fault_active && $stable(fault_code) && $stable(stop_request))
      else $error("latched fault changed without clear");

   c_ls3: cover property (@(posedge mclk) disable iff (!rst_n) hit[SMFM_F_LS3]);
   c_dir: cover property (@(posedge mclk) disable iff (!rst_n) hit[SMFM_F_POS] ##[1:20] hit[SMFM_F_NEG]);
   c_ramp: cover property (@(posedge mclk) disable iff (!rst_n) hit[SMFM_F_SS2]);
   c_record: cover property (@(posedge mclk) disable iff (!rst_n) rec_wr);
   c_clear: cover property (@(posedge mclk) disable iff (!rst_n) fault_active ##1 fault_clear ##1 !fault_active);
endmodule

/* File: sim/smfm_enc_model.sv */
// Encoder feedback model: the far side that hands one speed and position sample to the monitor.
// Assumes the bench raises req for one cycle, just after a rising edge of mclk.
`timescale 1ns/1ps
module smfm_enc_model (
   input wire logic mclk,
   input wire logic req,
   input wire smfm_pkg::smfm_fb_t req_fb,
   output logic fb_valid,
   output smfm_pkg::smfm_fb_t fb
);
   import smfm_pkg::*;
   initial begin
      fb_valid = 1'b0;
      fb = '0;
   end
   // One valid cycle per sample; between samples the lines flip so stale data never looks like a sample.
   always @(posedge mclk) begin
      fb_valid <= req;
      fb <= req ? req_fb : ~fb;
   end
endmodule

/* File: sim/safe_motion_fault_monitor_tb.sv */
// Self-checking bench for the safe motion fault monitor, one task per scenario.
// Assumes smfm_pkg, smfm_top and the encoder feedback model are compiled before it.
`timescale 1ns/1ps
module safe_motion_fault_monitor_tb;
   import smfm_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic req = 1'b0;
   smfm_fb_t req_fb = '0;
   logic fb_valid;
   smfm_fb_t fb;
   smfm_limits_t limits = '{24'd100, 24'd200, 24'd10, 24'd20, 24'd50, 24'd5, 24'd8};
   smfm_mon_t mon = '0;
   smfm_stop_t stop_cfg_ls = SMFM_STOP_TORQUE_OFF;
   smfm_stop_t stop_cfg_dir = SMFM_STOP_NONE;
   smfm_stop_t stop_cfg_ramp = SMFM_STOP_NONE;
   logic fault_clear = 1'b0;
   logic [1:0] rec_idx = 2'h0;
   logic [SMFM_NFAULT-1:0] fault_flags;
   logic [15:0] fault_code;
   logic fault_active;
   smfm_stop_t stop_request;
   smfm_fb_t rec_data;
   logic [15:0] rec_code;
   logic [2:0] rec_count;
   int fails = 0;
   int checked = 0;
   int exp_count = 0;

   // The clock toggles every 2.5 ns, a period of 5 ns.
   always #2.5 mclk = ~mclk;

   smfm_enc_model u_enc (.mclk(mclk), .req(req), .req_fb(req_fb), .fb_valid(fb_valid), .fb(fb));

   smfm_top #(.REC_DEPTH(4)) DUT (.mclk(mclk), .rst_n(rst_n), .fb_valid(fb_valid), .fb(fb), .limits(limits),
      .mon(mon), .stop_cfg_ls(stop_cfg_ls), .stop_cfg_dir(stop_cfg_dir), .stop_cfg_ramp(stop_cfg_ramp),
      .fault_clear(fault_clear), .rec_idx(rec_idx), .fault_flags(fault_flags), .fault_code(fault_code),
      .fault_active(fault_active), .stop_request(stop_request), .rec_data(rec_data), .rec_code(rec_code),
      .rec_count(rec_count));

   // Compare of a status value, widened to 16 bits.
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Compare of a stored feedback sample.
   task automatic chk_fb(input smfm_fb_t got, input smfm_fb_t exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Sends one sample through the model and returns once the monitor has judged it.
   task automatic send(input int s, input int p);
      req_fb = '{speed: s[23:0], pos_delta: p[23:0]};
      req = 1'b1;
      @(posedge mclk);
      #1 req = 1'b0;
      @(posedge mclk);
      #1;
   endtask

   // Nothing latched; used for samples that sit exactly on a limit or move the allowed way.
   task automatic no_fault();
      chk_val({9'h0, fault_flags}, 16'h0000);
      chk_val(fault_code, SMFM_CODE_NONE);
   endtask

   // Checks one latched fault, its response and, for torque-off, the stored record.
   task automatic expect_fault(input int b, input logic [15:0] code, input smfm_stop_t stp, input int s, input int p);
      chk_val({9'h0, fault_flags}, 16'h0001 << b);
      chk_val(fault_code, code);
      chk_val({15'h0, fault_active}, 16'h0001);
      chk_val({14'h0, stop_request}, {14'h0, stp});
      if (stp == SMFM_STOP_TORQUE_OFF) begin
         // The record count saturates at a full store, so only entries written below the depth are read back.
         if (exp_count < 4) begin
            exp_count++;
            rec_idx = 2'(exp_count - 1);
            @(posedge mclk);
            #1;
            chk_fb(rec_data, '{speed: s[23:0], pos_delta: p[23:0]});
            chk_val(rec_code, code);
         end
      end
      chk_val({13'h0, rec_count}, 16'(exp_count));
      fault_clear = 1'b1;
      @(posedge mclk);
      #1 fault_clear = 1'b0;
      chk_val({9'h0, fault_flags}, 16'h0000);
   endtask

   task automatic t_speed();
      mon = '0;
      mon.ls3 = 1'b1;
      send(100, 0);
      no_fault();
      send(-101, 3);
      expect_fault(SMFM_F_LS3, SMFM_CODE_LS3, SMFM_STOP_TORQUE_OFF, -101, 3);
      mon = '0;
      mon.ls4 = 1'b1;
      stop_cfg_ls = SMFM_STOP_FIRST;
      send(200, 0);
      no_fault();
      send(201, 0);
      expect_fault(SMFM_F_LS4, SMFM_CODE_LS4, SMFM_STOP_FIRST, 201, 0);
      $display("test speed stages done");
   endtask

   // Both directions from one table: d=0 positive lock, d=1 negative lock.
   task automatic t_dir();
      int sg;
      for (int d = 0; d < 2; d++) begin
         sg = d ? -1 : 1;
         mon = '0;
         mon.pos_lock = (d == 0);
         mon.neg_lock = (d == 1);
         stop_cfg_dir = d ? SMFM_STOP_TORQUE_OFF : SMFM_STOP_SECOND;
         send(sg * 10, sg * 20);
         no_fault();
         send(-sg * 50, -sg * 50);
         no_fault();
         send(0, sg * 21);
         expect_fault(SMFM_F_POS + d, d ? SMFM_CODE_NEG : SMFM_CODE_POS, stop_cfg_dir, 0, sg * 21);
         send(sg * 11, 0);
         expect_fault(SMFM_F_POS + d, d ? SMFM_CODE_NEG : SMFM_CODE_POS, stop_cfg_dir, sg * 11, 0);
      end
      $display("test direction locks done");
   endtask

   task automatic t_ramp();
      for (int d = 0; d < 2; d++) begin
         mon = '0;
         // An idle edge disarms the ramp history, so a mode change never compares against the old speed.
         @(posedge mclk);
         #1;
         mon.ss1_ramp = (d == 0);
         mon.ss2_ramp = (d == 1);
         stop_cfg_ramp = d ? SMFM_STOP_SECOND : SMFM_STOP_TORQUE_OFF;
         send(1000, 0);
         send(950, 0);
         no_fault();
         send(899, 0);
         expect_fault(SMFM_F_SS1 + d, d ? SMFM_CODE_SS2 : SMFM_CODE_SS1, stop_cfg_ramp, 899, 0);
      end
      $display("test stop ramps done");
   endtask

   task automatic t_sos();
      mon = '0;
      mon.safe_operating_stop = 1'b1;
      send(5, -8);
      no_fault();
      send(0, -9);
      expect_fault(SMFM_F_SOS, SMFM_CODE_SOS, SMFM_STOP_TORQUE_OFF, 0, -9);
      send(-6, 0);
      expect_fault(SMFM_F_SOS, SMFM_CODE_SOS, SMFM_STOP_TORQUE_OFF, -6, 0);
      $display("test operating stop done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Main sequence; reset is held for six cycles, then released just after an edge.
   initial begin
      repeat (6) @(posedge mclk);
      #1 rst_n = 1'b1;
      no_fault();
      chk_val({13'h0, rec_count}, 16'h0000);
      t_speed();
      t_dir();
      t_ramp();
      t_sos();
      final_report();
   end

   // The tests need under seventy cycles; the watchdog allows about sixty times that.
   initial begin
      #20000;
      fails++;
      $display("watchdog expired");
      final_report();
   end
endmodule
